// file: include/gcss_pkg.sv
`default_nettype none
package gcss_pkg;

  // ****************************************
  // clock and time
  // ****************************************
  localparam int unsigned CLK_PERIOD_NS    = 50;
  localparam int unsigned VGS_DEGLITCH_NS  = 200;
  // least time, rounded up to whole cycles
  localparam int unsigned VGS_DEGLITCH_CYC =
    (VGS_DEGLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [7:0]  CURRENT_CFG_OFFS = 8'h00;
  localparam logic [7:0]  TIMING_CFG_OFFS  = 8'h04;
  localparam logic [7:0]  STATUS_OFFS      = 8'h08;
  localparam logic [31:0] CURRENT_CFG_RST  = 32'h0000_0000;
  localparam logic [31:0] TIMING_CFG_RST   = 32'h0000_0000;

  // current config field positions
  localparam int unsigned HS_ON_POS   = 0;
  localparam int unsigned HS_OFF_POS  = 4;
  localparam int unsigned LS_ON_POS   = 8;
  localparam int unsigned LS_OFF_POS  = 12;
  localparam int unsigned PRE_SRC_POS = 16;
  localparam int unsigned PRE_SNK_POS = 20;
  localparam int unsigned PRE_EN_POS  = 24;
  // timing config field positions
  localparam int unsigned T1_POS      = 0;
  localparam int unsigned T2_POS      = 8;
  localparam int unsigned T3_POS      = 16;
  localparam int unsigned T4_POS      = 24;
  // status field positions
  localparam int unsigned CMD_POS     = 0;
  localparam int unsigned BUSY_POS    = 8;
  localparam int unsigned HOLD_POS    = 16;

  // ****************************************
  // drive levels: 0..15 programmed, then full and hold
  // ****************************************
  localparam logic [4:0] LVL_FULL = 5'h10;
  localparam logic [4:0] LVL_HOLD = 5'h11;

  typedef struct packed {
    logic       src;
    logic [4:0] level;
  } gcss_drive_t;

  typedef struct packed {
    logic [7:0] t1;
    logic [7:0] t2;
    logic [7:0] t3;
    logic [7:0] t4;
    logic [3:0] hs_on;
    logic [3:0] hs_off;
    logic [3:0] ls_on;
    logic [3:0] ls_off;
    logic [3:0] pre_src;
    logic [3:0] pre_snk;
    logic       pre_en;
  } gcss_cfg_t;

  typedef enum logic [3:0] {
    PH_ON_PRE, PH_ON_SLEW, PH_ON_FULL, PH_ON_HOLD,
    PH_OFF_PRE, PH_OFF_SLEW, PH_OFF_FULL, PH_OFF_HOLD
  } gcss_phase_t;

  typedef struct packed {
    gcss_phase_t phase;
    logic [7:0]  cnt;
    logic        cmd_last;
    logic [3:0]  deg;
    gcss_cfg_t   cfg_cap;
    gcss_drive_t drive;
  } gcss_seq_state_t;

  localparam gcss_seq_state_t SEQ_RST = '{
    phase: PH_OFF_HOLD, cnt: 8'h00, cmd_last: 1'b0, deg: 4'h0,
    cfg_cap: '0, drive: '{src: 1'b0, level: LVL_HOLD}};

  // ****************************************
  // apb carriers
  // ****************************************
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [3:0]  pstrb;
  } gcss_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } gcss_apb_rsp_t;

endpackage
`default_nettype wire

// file: rtl/gcss_gate_seq.sv
`timescale 1ns/1ps
`default_nettype none
module gcss_gate_seq #(
  parameter bit          HIGH_SIDE = 1'b1,
  parameter int unsigned DEG_CYC   = gcss_pkg::VGS_DEGLITCH_CYC
) (
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  cmd,
  input  wire logic                  vgs_charged,
  input  wire logic                  vgs_discharged,
  input  wire gcss_pkg::gcss_cfg_t   cfg,
  output var  gcss_pkg::gcss_drive_t drive,
  output var  gcss_pkg::gcss_phase_t phase
);

  gcss_pkg::gcss_seq_state_t s_reg;
  gcss_pkg::gcss_seq_state_t s_next;
  logic                      cond;

  // ****************************************
  // phase helpers
  // ****************************************
  // length of a timed phase in cycles
  function automatic logic [7:0] dur(gcss_pkg::gcss_phase_t p,
                                     gcss_pkg::gcss_cfg_t c);
    case (p)
      gcss_pkg::PH_ON_PRE:   dur = c.t1;
      gcss_pkg::PH_ON_SLEW:  dur = c.t2;
      gcss_pkg::PH_OFF_PRE:  dur = c.t3;
      gcss_pkg::PH_OFF_SLEW: dur = c.t4;
      default:               dur = 8'h00;
    endcase
  endfunction

  // skip phases whose duration is zero
  function automatic gcss_pkg::gcss_phase_t settle(
    gcss_pkg::gcss_phase_t p, gcss_pkg::gcss_cfg_t c);
    gcss_pkg::gcss_phase_t q;
    q = p;
    if (q == gcss_pkg::PH_ON_PRE && c.t1 == 8'h00) q = gcss_pkg::PH_ON_SLEW;
    if (q == gcss_pkg::PH_ON_SLEW && c.t2 == 8'h00) q = gcss_pkg::PH_ON_FULL;
    if (q == gcss_pkg::PH_OFF_PRE && c.t3 == 8'h00) q = gcss_pkg::PH_OFF_SLEW;
    if (q == gcss_pkg::PH_OFF_SLEW && c.t4 == 8'h00) q = gcss_pkg::PH_OFF_FULL;
    return q;
  endfunction

  // gate current for each phase
  function automatic gcss_pkg::gcss_drive_t drive_of(
    gcss_pkg::gcss_phase_t p, gcss_pkg::gcss_cfg_t c);
    drive_of.src = (p == gcss_pkg::PH_ON_PRE || p == gcss_pkg::PH_ON_SLEW ||
                    p == gcss_pkg::PH_ON_FULL || p == gcss_pkg::PH_ON_HOLD);
    case (p)
      gcss_pkg::PH_ON_PRE:   drive_of.level = c.pre_en ? {1'b0, c.pre_src}
                                            : gcss_pkg::LVL_FULL;
      gcss_pkg::PH_ON_SLEW:  drive_of.level = HIGH_SIDE ? {1'b0, c.hs_on}
                                            : {1'b0, c.ls_on};
      gcss_pkg::PH_OFF_PRE:  drive_of.level = c.pre_en ? {1'b0, c.pre_snk}
                                            : gcss_pkg::LVL_FULL;
      gcss_pkg::PH_OFF_SLEW: drive_of.level = HIGH_SIDE ? {1'b0, c.hs_off}
                                            : {1'b0, c.ls_off};
      gcss_pkg::PH_ON_HOLD,
      gcss_pkg::PH_OFF_HOLD: drive_of.level = gcss_pkg::LVL_HOLD;
      default:               drive_of.level = gcss_pkg::LVL_FULL;
    endcase
  endfunction

  // ****************************************
  // sequencer
  // ****************************************
  // next state: start, timers, deglitch and hold switch
  always_comb begin
    s_next          = s_reg;
    s_next.cmd_last = cmd;
    cond = s_reg.cmd_last ? vgs_charged : vgs_discharged;
    if (cmd != s_reg.cmd_last) begin
      s_next.cfg_cap = cfg; // settings taken only at a pwm edge
      s_next.deg     = 4'h0;
      s_next.phase   = settle(cmd ? gcss_pkg::PH_ON_PRE
                                  : gcss_pkg::PH_OFF_PRE, cfg);
      s_next.cnt     = dur(s_next.phase, cfg);
    end else begin
      if (!cond) begin
        s_next.deg = 4'h0;
      end else if (s_reg.deg != 4'hF) begin
        s_next.deg = s_reg.deg + 4'h1;
      end
      if (cond && s_reg.deg >= 4'(DEG_CYC - 1) &&
          s_reg.phase != gcss_pkg::PH_ON_HOLD &&
          s_reg.phase != gcss_pkg::PH_OFF_HOLD) begin
        // persisting comparator trip selects hold
        s_next.phase = s_reg.cmd_last ? gcss_pkg::PH_ON_HOLD
                                      : gcss_pkg::PH_OFF_HOLD;
        s_next.cnt   = 8'h00;
      end else if (dur(s_reg.phase, s_reg.cfg_cap) != 8'h00) begin
        if (s_reg.cnt == 8'h01) begin
          // timer expired: pre to slew to full
          case (s_reg.phase)
            gcss_pkg::PH_ON_PRE:
              s_next.phase = settle(gcss_pkg::PH_ON_SLEW, s_reg.cfg_cap);
            gcss_pkg::PH_ON_SLEW:  s_next.phase = gcss_pkg::PH_ON_FULL;
            gcss_pkg::PH_OFF_PRE:
              s_next.phase = settle(gcss_pkg::PH_OFF_SLEW, s_reg.cfg_cap);
            gcss_pkg::PH_OFF_SLEW: s_next.phase = gcss_pkg::PH_OFF_FULL;
            default:               s_next.phase = s_reg.phase;
          endcase
          s_next.cnt = dur(s_next.phase, s_reg.cfg_cap);
        end else begin
          s_next.cnt = s_reg.cnt - 8'h01;
        end
      end
    end
    // per-phase current
    s_next.drive = drive_of(s_next.phase, s_next.cfg_cap);
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg <= gcss_pkg::SEQ_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  assign drive = s_reg.drive;
  assign phase = s_reg.phase;

endmodule
`default_nettype wire

// file: rtl/gcss_sequencer.sv
// The address map and register access over APB were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - turn-on starts with pre-charge current for the first duration
// - then the side's turn-on current for the second duration
// - then full 1.5A current until the gate is charged
// - turn-off mirrors it: pre-discharge, side turn-off, then full
// - durations and pre currents shared; slew currents per side
// - pre-charge enable cleared means pre phases use full current
// - pre current has 16 codes plus full 1.5A
// - second duration zero goes from pre-charge straight to full
// - zero second, third or fourth duration skips that phase
// - comparator trip switches gate current to hold
// - comparator must persist for the deglitch time to trip
// - new settings apply only at pwm edges, never mid-transition
module gcss_sequencer #(
  parameter int unsigned DEG_CYC = gcss_pkg::VGS_DEGLITCH_CYC
) (
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire gcss_pkg::gcss_apb_req_t apb_req,
  output var  gcss_pkg::gcss_apb_rsp_t apb_rsp,
  input  wire logic [2:0]            high_side_pwm_input,
  input  wire logic [2:0]            low_side_pwm_input,
  input  wire logic [5:0]            vgs_charged,
  input  wire logic [5:0]            vgs_discharged,
  output var  gcss_pkg::gcss_drive_t gate_drive [6]
);

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic [17:0]             sync1;
    logic [17:0]             sync2;
    logic [17:0]             sync3;
    logic [17:0]             filt;
    logic [31:0]             current_cfg;
    logic [31:0]             timing_cfg;
    gcss_pkg::gcss_apb_rsp_t rsp;
    logic                    cmd0_d;
    logic [9:0]              since_on;
    logic [9:0]              since_off;
    gcss_pkg::gcss_cfg_t     cap0;
    logic [3:0]              chg_run;
  } gcss_top_state_t;

  gcss_top_state_t       st_reg;
  gcss_top_state_t       st_next;
  gcss_pkg::gcss_cfg_t   cfg;
  gcss_pkg::gcss_phase_t seq_phase [6];
  logic [5:0]            cmd;
  logic [31:0]           status;
  logic                  setup;
  logic                  access;

  if (DEG_CYC < 1 || DEG_CYC > 15) begin : g_chk
    $error("deglitch count must be 1 to 15");
  end

  // ****************************************
  // decode helpers
  // ****************************************
  // register present at this address
  function automatic logic mapped(logic [7:0] a);
    return a == gcss_pkg::CURRENT_CFG_OFFS ||
           a == gcss_pkg::TIMING_CFG_OFFS || a == gcss_pkg::STATUS_OFFS;
  endfunction

  // byte-lane merge of a write
  function automatic logic [31:0] merge(logic [31:0] old, logic [31:0] wd,
                                        logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) r[i*8 +: 8] = wd[i*8 +: 8];
    end
    return r;
  endfunction

  // field unpacking of both config words
  function automatic gcss_pkg::gcss_cfg_t to_cfg(logic [31:0] cur,
                                                 logic [31:0] tim);
    gcss_pkg::gcss_cfg_t c;
    c.t1      = tim[gcss_pkg::T1_POS +: 8];
    c.t2      = tim[gcss_pkg::T2_POS +: 8];
    c.t3      = tim[gcss_pkg::T3_POS +: 8];
    c.t4      = tim[gcss_pkg::T4_POS +: 8];
    c.hs_on   = cur[gcss_pkg::HS_ON_POS +: 4];
    c.hs_off  = cur[gcss_pkg::HS_OFF_POS +: 4];
    c.ls_on   = cur[gcss_pkg::LS_ON_POS +: 4];
    c.ls_off  = cur[gcss_pkg::LS_OFF_POS +: 4];
    c.pre_src = cur[gcss_pkg::PRE_SRC_POS +: 4];
    c.pre_snk = cur[gcss_pkg::PRE_SNK_POS +: 4];
    c.pre_en  = cur[gcss_pkg::PRE_EN_POS];
    return c;
  endfunction

  // ****************************************
  // pins, config and status
  // ****************************************
  // shared settings for all six drivers
  assign cfg    = to_cfg(st_reg.current_cfg, st_reg.timing_cfg);
  assign setup  = apb_req.psel && !apb_req.penable;
  assign access = apb_req.psel && apb_req.penable && st_reg.rsp.pready;

  // gate 2k is high side of phase k, 2k+1 the low side
  always_comb begin
    status = 32'h0000_0000;
    for (int k = 0; k < 3; k++) begin
      cmd[2*k]     = st_reg.filt[k];
      cmd[2*k + 1] = st_reg.filt[3 + k];
    end
    for (int g = 0; g < 6; g++) begin
      status[gcss_pkg::CMD_POS + g]  = cmd[g];
      status[gcss_pkg::BUSY_POS + g] =
        seq_phase[g] != gcss_pkg::PH_ON_HOLD &&
        seq_phase[g] != gcss_pkg::PH_OFF_HOLD;
      status[gcss_pkg::HOLD_POS + g] =
        seq_phase[g] == gcss_pkg::PH_ON_HOLD ||
        seq_phase[g] == gcss_pkg::PH_OFF_HOLD;
    end
  end

  // ****************************************
  // next state
  // ****************************************
  // synchronisers, apb slave and gate-0 observation counters
  always_comb begin
    st_next       = st_reg;
    st_next.sync1 = {vgs_discharged, vgs_charged,
                     low_side_pwm_input, high_side_pwm_input};
    st_next.sync2 = st_reg.sync1;
    st_next.sync3 = st_reg.sync2;
    // a bit changes once the second and third stage agree
    for (int b = 0; b < 18; b++) begin
      if (st_reg.sync2[b] == st_reg.sync3[b]) begin
        st_next.filt[b] = st_reg.sync3[b];
      end
    end
    // apb: answer one access cycle after setup
    st_next.rsp = '0;
    if (setup) begin
      st_next.rsp.pready  = 1'b1;
      st_next.rsp.pslverr = !mapped(apb_req.paddr);
      if (!apb_req.pwrite) begin
        case (apb_req.paddr)
          gcss_pkg::CURRENT_CFG_OFFS: st_next.rsp.prdata = st_reg.current_cfg;
          gcss_pkg::TIMING_CFG_OFFS:  st_next.rsp.prdata = st_reg.timing_cfg;
          gcss_pkg::STATUS_OFFS:      st_next.rsp.prdata = status;
          default:                    st_next.rsp.prdata = 32'h0000_0000;
        endcase
      end
    end
    if (access && apb_req.pwrite && mapped(apb_req.paddr)) begin
      if (apb_req.paddr == gcss_pkg::CURRENT_CFG_OFFS) begin
        st_next.current_cfg = merge(st_reg.current_cfg, apb_req.pwdata,
                                    apb_req.pstrb);
      end
      if (apb_req.paddr == gcss_pkg::TIMING_CFG_OFFS) begin
        st_next.timing_cfg = merge(st_reg.timing_cfg, apb_req.pwdata,
                                   apb_req.pstrb);
      end
    end
    // cycles since the last gate-0 edge, with settings then in force
    st_next.cmd0_d = st_reg.filt[0];
    if (st_reg.since_on != 10'h3FF) begin
      st_next.since_on = st_reg.since_on + 10'h001;
    end
    if (st_reg.since_off != 10'h3FF) begin
      st_next.since_off = st_reg.since_off + 10'h001;
    end
    if (st_reg.filt[0] && !st_reg.cmd0_d) begin
      st_next.since_on = 10'h001;
      st_next.cap0     = cfg;
    end
    if (!st_reg.filt[0] && st_reg.cmd0_d) begin
      st_next.since_off = 10'h001;
      st_next.cap0      = cfg;
    end
    if (!st_reg.filt[6]) begin
      st_next.chg_run = 4'h0;
    end else if (st_reg.chg_run != 4'hF) begin
      st_next.chg_run = st_reg.chg_run + 4'h1;
    end
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg             <= '0;
      st_reg.current_cfg <= gcss_pkg::CURRENT_CFG_RST;
      st_reg.timing_cfg  <= gcss_pkg::TIMING_CFG_RST;
      st_reg.since_on    <= 10'h3FF;
      st_reg.since_off   <= 10'h3FF;
    end else begin
      st_reg <= st_next;
    end
  end

  assign apb_rsp = st_reg.rsp;

  // ****************************************
  // gate sequencers
  // ****************************************
  // one current sequencer per driver
  for (genvar g = 0; g < 6; g++) begin : g_gate
    gcss_gate_seq #(
      .HIGH_SIDE ((g % 2) == 0),
      .DEG_CYC   (DEG_CYC)
    ) u_seq (
      .pclk           (pclk),
      .presetn        (presetn),
      .cmd            (cmd[g]),
      .vgs_charged    (st_reg.filt[6 + g]),
      .vgs_discharged (st_reg.filt[12 + g]),
      .cfg            (cfg),
      .drive          (gate_drive[g]),
      .phase          (seq_phase[g])
    );
  end

  // ****************************************
  // checks on gate 0 and the bus
  // ****************************************
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence apb_setup_s;
    apb_req.psel && !apb_req.penable;
  endsequence

  sequence ready_pulse_s;
    apb_rsp.pready ##1 !apb_rsp.pready;
  endsequence

  sequence on_stable_s;
    st_reg.filt[0] && gate_drive[0].level != gcss_pkg::LVL_HOLD;
  endsequence

  sequence off_stable_s;
    !st_reg.filt[0] && gate_drive[0].level != gcss_pkg::LVL_HOLD;
  endsequence

  pre_charge_level_a: assert property (
    on_stable_s and (st_reg.since_on == 10'h001 && st_reg.cap0.t1 != 8'h00)
    |-> gate_drive[0].src && gate_drive[0].level ==
        (st_reg.cap0.pre_en ? {1'b0, st_reg.cap0.pre_src} : gcss_pkg::LVL_FULL))
    else $error("pre-charge current wrong at turn-on start");

  slew_on_level_a: assert property (
    on_stable_s and (st_reg.cap0.t2 != 8'h00 &&
    st_reg.since_on == 10'(st_reg.cap0.t1) + 10'h001)
    |-> gate_drive[0].src &&
        gate_drive[0].level == {1'b0, st_reg.cap0.hs_on})
    else $error("turn-on slew current not applied after first phase");

  full_on_level_a: assert property (
    on_stable_s and (st_reg.since_on ==
    10'(st_reg.cap0.t1) + 10'(st_reg.cap0.t2) + 10'h001)
    |-> gate_drive[0].src && gate_drive[0].level == gcss_pkg::LVL_FULL)
    else $error("full current not applied after timed phases");

  pre_off_level_a: assert property (
    off_stable_s and (st_reg.since_off == 10'h001 &&
    st_reg.cap0.t3 != 8'h00)
    |-> !gate_drive[0].src && gate_drive[0].level ==
        (st_reg.cap0.pre_en ? {1'b0, st_reg.cap0.pre_snk} : gcss_pkg::LVL_FULL))
    else $error("pre-discharge current wrong at turn-off start");

  slew_off_level_a: assert property (
    off_stable_s and (st_reg.cap0.t4 != 8'h00 &&
    st_reg.since_off == 10'(st_reg.cap0.t3) + 10'h001)
    |-> !gate_drive[0].src &&
        gate_drive[0].level == {1'b0, st_reg.cap0.hs_off})
    else $error("turn-off slew current not applied after third phase");

  full_off_level_a: assert property (
    off_stable_s and (st_reg.since_off ==
    10'(st_reg.cap0.t3) + 10'(st_reg.cap0.t4) + 10'h001)
    |-> !gate_drive[0].src && gate_drive[0].level == gcss_pkg::LVL_FULL)
    else $error("full sink current not applied after timed phases");

  hold_deglitch_a: assert property (
    $rose(gate_drive[0].level == gcss_pkg::LVL_HOLD) && st_reg.filt[0]
    |-> st_reg.chg_run >= 4'(DEG_CYC))
    else $error("hold entered before comparator persisted");

  apb_ready_pulse_a: assert property (
    apb_setup_s |=> ready_pulse_s)
    else $error("pready not a single pulse after setup");

endmodule
`default_nettype wire

// file: dv/gcss_gate_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// gates of the six inverter mosfets
// ****************************************
module gcss_gate_model (
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic [7:0]            delay,
  input  wire logic                  glitch,
  input  wire gcss_pkg::gcss_drive_t gate_drive [6],
  output wire logic [5:0]            vgs_charged,
  output wire logic [5:0]            vgs_discharged
);
  for (genvar g = 0; g < 6; g++) begin : gl
    logic [7:0] cnt;
    logic       src_q;
    logic       near;
    // ramp timer restarts at each change of direction
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        cnt   <= 8'hFF;
        src_q <= 1'b0;
      end else begin
        src_q <= gate_drive[g].src;
        if (gate_drive[g].src != src_q) cnt <= 8'h00;
        else if (cnt != 8'hFF) cnt <= cnt + 8'h01;
      end
    end
    // threshold reached, or a two-cycle noise pulse halfway
    assign near = (cnt >= delay) ||
                  (glitch && (cnt[7:1] == {1'b0, delay[7:2]}));
    assign vgs_charged[g]    = src_q & near;
    assign vgs_discharged[g] = ~src_q & near;
  end
endmodule
`default_nettype wire

// file: dv/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam logic [7:0] TIM  = gcss_pkg::TIMING_CFG_OFFS;
  localparam logic [7:0] CUR  = gcss_pkg::CURRENT_CFG_OFFS;
  localparam logic [4:0] FULL = gcss_pkg::LVL_FULL;
  logic                    pclk;
  logic                    presetn;
  gcss_pkg::gcss_apb_req_t req;
  gcss_pkg::gcss_apb_rsp_t rsp;
  logic [2:0]              hs;
  logic [2:0]              ls;
  logic [5:0]              vch;
  logic [5:0]              vdis;
  gcss_pkg::gcss_drive_t   drv [6];
  int                      num_errors = 0;
  int                      total_checks = 0;

  gcss_sequencer i_gcss_sequencer (
    .pclk                (pclk),
    .presetn             (presetn),
    .apb_req             (req),
    .apb_rsp             (rsp),
    .high_side_pwm_input (hs),
    .low_side_pwm_input  (ls),
    .vgs_charged         (vch),
    .vgs_discharged      (vdis),
    .gate_drive          (drv)
  );
  // noise pulses always on, ramp of 40 cycles
  gcss_gate_model i_gcss_gate_model (
    .pclk           (pclk),
    .presetn        (presetn),
    .delay          (8'h28),
    .glitch         (1'b1),
    .gate_drive     (drv),
    .vgs_charged    (vch),
    .vgs_discharged (vdis)
  );

  // ****************************************
  // helpers
  // ****************************************
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  task automatic complete_run();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] rd,
                     output logic err);
    @(posedge pclk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a,
             pwdata: d, pstrb: 4'hF};
    @(posedge pclk);
    req.penable <= 1'b1;
    // hold the access until pready; a hang is left to the watchdog
    do begin
      @(posedge pclk);
    end while (rsp.pready !== 1'b1);
    rd = rsp.prdata;
    err = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    logic        e;
    apb(1'b1, a, d, x, e);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp,
                        input logic experr);
    logic [31:0] d;
    logic        e;
    apb(1'b0, a, 32'h0, d, e);
    check(d, exp);
    check(32'(e), 32'(experr));
  endtask

  task automatic step();
    @(posedge pclk);
    #1;
  endtask

  // one pwm edge on gate g, then the whole level sequence
  task automatic seq(input int g, input logic s, input logic [4:0] l1,
                     input int n1, input logic [4:0] l2, input int n2);
    int k;
    @(posedge pclk);
    if (g % 2) ls[g/2] <= s;
    else hs[g/2] <= s;
    k = 0;
    while (drv[g].level === gcss_pkg::LVL_HOLD && k < 20) begin
      step();
      k++;
    end
    repeat (n1) begin
      check(32'(drv[g]), 32'({s, l1}));
      step();
    end
    repeat (n2) begin
      check(32'(drv[g]), 32'({s, l2}));
      step();
    end
    check(32'(drv[g]), 32'({s, FULL}));
    k = 0;
    while (drv[g].level !== gcss_pkg::LVL_HOLD && k < 80) begin
      step();
      k++;
    end
    check(32'(drv[g]), 32'({s, gcss_pkg::LVL_HOLD}));
    check(32'(k > 30), 32'h1);
  endtask

  // ****************************************
  // tests
  // ****************************************
  initial begin
    req = '0;
    hs = '0;
    ls = '0;
    presetn = 1'b0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk(CUR, gcss_pkg::CURRENT_CFG_RST, 1'b0);
    rd_chk(TIM, gcss_pkg::TIMING_CFG_RST, 1'b0);
    rd_chk(8'h0C, 32'h0, 1'b1);
    wr(CUR, 32'h0165_4321);
    wr(TIM, 32'h0302_0302);
    rd_chk(TIM, 32'h0302_0302, 1'b0);
    // timing cleared while the low side is mid-transition
    fork
      seq(1, 1'b1, 5'h05, 2, 5'h03, 3);
      begin
        repeat (6) @(posedge pclk);
        wr(TIM, 32'h0000_0000);
        rd_chk(gcss_pkg::STATUS_OFFS, 32'h003D_0202, 1'b0);
      end
    join
    wr(gcss_pkg::STATUS_OFFS, 32'hFFFF_FFFF);
    rd_chk(gcss_pkg::STATUS_OFFS, 32'h003F_0002, 1'b0);
    wr(TIM, 32'h0302_0302);
    seq(1, 1'b0, 5'h06, 2, 5'h04, 3);
    // low side is off before the high side switches
    for (int c = 0; c < 16; c++) begin
      wr(CUR, {8'h01, 4'(15 - c), 4'(c), 16'h4321});
      seq(0, 1'b1, 5'(c), 2, 5'h01, 3);
      seq(0, 1'b0, 5'(15 - c), 2, 5'h02, 3);
    end
    wr(TIM, 32'h0002_0002);
    seq(2, 1'b1, 5'h0F, 2, 5'h00, 0);
    seq(2, 1'b0, 5'h00, 2, 5'h00, 0);
    wr(CUR, 32'h0065_4321);
    wr(TIM, 32'h0302_0302);
    seq(4, 1'b1, FULL, 2, 5'h01, 3);
    seq(4, 1'b0, FULL, 2, 5'h02, 3);
    seq(3, 1'b1, FULL, 2, 5'h03, 3);
    seq(3, 1'b0, FULL, 2, 5'h04, 3);
    wr(CUR, 32'h0165_4321);
    seq(5, 1'b1, 5'h05, 2, 5'h03, 3);
    seq(5, 1'b0, 5'h06, 2, 5'h04, 3);
    complete_run();
  end

  // hang guard
  initial begin
    repeat (10000) @(posedge pclk);
    num_errors++;
    complete_run();
  end
endmodule
`default_nettype wire
